/* src/dsr_pkg.sv */
// Package: register map, field layout, codes and timing for the diagnostic status reporter
package dsr_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_HZ = 20_000_000;
	localparam int FLASH_HALF_MS = 250; // Half period of every flashing lamp
	localparam int FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;
	localparam int SELFTEST_US = 100; // Power-up self test length
	localparam int SELFTEST_CYC = (CLK_HZ / 1_000_000) * SELFTEST_US;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_ERROR_WORD = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_CONFIG = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
	localparam logic [7:0] OFS_OUT_BASE = 8'h20;
	localparam logic [7:0] OFS_IN_BASE = 8'h40;

	// ****************************************
	// Error word layout
	// ****************************************
	localparam int ERR_CLASS_LSB = 9;
	localparam int ERR_CLASS_W = 3;
	localparam int ERR_EXT_W = 9;
	localparam logic [2:0] CLASS_NONE = 3'h0;
	localparam logic [2:0] CLASS_HW = 3'h1;
	localparam logic [2:0] CLASS_CFG = 3'h2;
	localparam logic [8:0] EXT_GENERAL = 9'h000;
	localparam logic [8:0] EXT_POWERUP = 9'h001;

	// ****************************************
	// Control bits
	// ****************************************
	localparam int CTRL_RUN = 0;
	localparam int CTRL_FORCE_EN = 1;
	localparam int CTRL_FORCES = 2;
	localparam int CTRL_CPU_HW = 3;
	localparam int CTRL_APP_FAULT = 4;

	// ****************************************
	// Config: two range bits per channel, value 3 is unsupported
	// ****************************************
	localparam logic [1:0] RANGE_BAD = 2'h3;

	// ****************************************
	// Interrupt bits
	// ****************************************
	localparam int IRQ_CFG_ERR = 0;
	localparam int IRQ_HW_ERR = 1;
	localparam int IRQ_RANGE = 2;
	localparam int IRQ_RUN_LOST = 3;
	localparam int IRQ_W = 4;

	// Lamps driven to the front panel
	typedef struct packed {
		logic supply;
		logic execute;
		logic error;
		logic override;
		logic module_ok;
	} dsr_lamps_t;

	// Module operating states
	typedef enum logic [1:0] {
		ST_SELFTEST,
		ST_NORMAL,
		ST_FAULT
	} dsr_state_t;

endpackage : dsr_pkg

/* src/dsr_flasher.sv */
// Flash-rate divider: one shared toggle for all flashing lamps
module dsr_flasher #(
	parameter int HALF_CYC = dsr_pkg::FLASH_HALF_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Flash phase
	output logic phase
);
	import dsr_pkg::*;

	logic [31:0] count;

	initial begin
		if (HALF_CYC < 1) $error("HALF_CYC must be at least 1");
	end

	// Count half periods, toggle phase at each end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			count <= 32'h0;
			phase <= 1'b0;
		end else if (count == 32'(HALF_CYC - 1)) begin
			count <= 32'h0;
			phase <= ~phase;
		end else begin
			count <= count + 32'h1;
		end
	end

endmodule : dsr_flasher

/* src/dsr_top.sv */
// Diagnostic status reporter: lamps, module error word, fault responses, APB registers
//
// How it works
// - No fault: supply and execution lamps steadily lit.
// - Forcing enabled with forces installed: override lamp steady on.
// - Forcing disabled with forces installed: override lamp flashes.
// - Controller hardware fault: supply and error lamps steady on.
// - Channel range flags reach input data; hardware and config errors reported.
// - Any module fault forces every analog output to zero.
// - Power-up self test first; status lamp lit only in proper operation.
// - Range and config errors are recoverable; module keeps operating.
// - A critical module error takes the system out of run mode.
// - Error word is 16 bits: class in 11..9, extended in 8..0.
// - Class codes: 000 none, 001 hardware, 010 configuration.
// - Class none always means extended field is zero.
// - Hardware errors give 2 in the third hex digit.
// - Invalid configuration is discarded; previous one kept; config error raised.
// - Hardware class with extended 1 means power-up reset state.
// - Config extended code names the offending channel, 1 for channel 0.
module dsr_top #(
	parameter int CHANNELS = 4,
	parameter int DATA_W = 16,
	parameter int SELFTEST_CYCLES = dsr_pkg::SELFTEST_CYC,
	parameter int FLASH_HALF = dsr_pkg::FLASH_HALF_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog front end (asynchronous)
	input wire logic [CHANNELS-1:0] ch_over,
	input wire logic [CHANNELS-1:0] ch_under,
	input wire logic hw_fault_in,
	input wire logic selftest_fail,
	// Analog outputs
	output logic [CHANNELS*DATA_W-1:0] analog_out,
	// Front panel
	output dsr_pkg::dsr_lamps_t lamps,
	// System
	output logic run_mode,
	output logic irq
);
	import dsr_pkg::*;

	initial begin
		if (CHANNELS < 1 || CHANNELS > 8) $error("CHANNELS must be 1 to 8");
		if (DATA_W < 1 || DATA_W > 32) $error("DATA_W must be 1 to 32");
		if (SELFTEST_CYCLES < 1) $error("SELFTEST_CYCLES must be at least 1");
	end

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [CHANNELS-1:0] over_s1, over_s2, under_s1, under_s2;
	logic hw_s1, hw_s2, stf_s1, stf_s2;

	// Pins come from outside the clock domain
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			over_s1 <= '0;
			over_s2 <= '0;
			under_s1 <= '0;
			under_s2 <= '0;
			hw_s1 <= 1'b0;
			hw_s2 <= 1'b0;
			stf_s1 <= 1'b0;
			stf_s2 <= 1'b0;
		end else begin
			over_s1 <= ch_over;
			over_s2 <= over_s1;
			under_s1 <= ch_under;
			under_s2 <= under_s1;
			hw_s1 <= hw_fault_in;
			hw_s2 <= hw_s1;
			stf_s1 <= selftest_fail;
			stf_s2 <= stf_s1;
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	// First channel with an unsupported range, CHANNELS if none
	function automatic logic [3:0] first_bad(input logic [15:0] cfg);
		logic [3:0] idx;
		idx = 4'(CHANNELS);
		for (int i = CHANNELS - 1; i >= 0; i--) begin
			if (cfg[2*i +: 2] == RANGE_BAD) idx = 4'(i);
		end
		return idx;
	endfunction : first_bad

	// Assemble the 16-bit error word, top digit zero
	function automatic logic [15:0] pack_err(input logic [2:0] cls, input logic [8:0] ext);
		return {4'h0, cls, ext};
	endfunction : pack_err

	// ****************************************
	// Registers and state
	// ****************************************
	dsr_state_t state;
	logic [31:0] st_count;
	logic [4:0] ctrl;
	logic [15:0] config_q;
	logic [2:0] err_class;
	logic [8:0] err_ext;
	logic [IRQ_W-1:0] irq_stat, irq_mask;
	logic [DATA_W-1:0] out_val [CHANNELS];
	logic phase;

	wire apb_wr = psel && penable && pwrite;
	wire apb_rd_setup = psel && !penable && !pwrite;
	wire [3:0] bad_ch = first_bad(pwdata[15:0]);
	wire cfg_wr = apb_wr && paddr == OFS_CONFIG;
	wire cfg_bad = cfg_wr && bad_ch != 4'(CHANNELS);
	wire module_fault = state == ST_FAULT;
	wire range_any = |over_s2 || |under_s2;

	// Shared flash rate for every flashing lamp
	dsr_flasher #(.HALF_CYC(FLASH_HALF)) u_flash (
		.clk(clk),
		.rst_b(rst_b),
		.phase(phase)
	);

	// Module state: self test, then normal or latched fault
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state <= ST_SELFTEST;
			st_count <= 32'h0;
		end else begin
			case (state)
				ST_SELFTEST: begin
					if (stf_s2) begin
						state <= ST_FAULT;
					end else if (st_count == 32'(SELFTEST_CYCLES - 1)) begin
						state <= ST_NORMAL;
					end else begin
						st_count <= st_count + 32'h1;
					end
				end
				ST_NORMAL: begin
					if (hw_s2) state <= ST_FAULT; // Range and config errors do not stop it
				end
				default: state <= ST_FAULT; // Hardware fault needs a power cycle
			endcase
		end
	end

	// Error word: power-up, hardware or configuration class
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			err_class <= CLASS_HW;
			err_ext <= EXT_POWERUP;
		end else if (state == ST_SELFTEST && !stf_s2 && st_count == 32'(SELFTEST_CYCLES - 1)) begin
			err_class <= CLASS_NONE;
			err_ext <= '0;
		end else if ((state == ST_SELFTEST && stf_s2) || (state == ST_NORMAL && hw_s2)) begin
			err_class <= CLASS_HW;
			err_ext <= EXT_GENERAL;
		end else if (cfg_bad && state == ST_NORMAL) begin
			err_class <= CLASS_CFG;
			err_ext <= 9'(bad_ch) + 9'h1;
		end else if (cfg_wr && state == ST_NORMAL && err_class == CLASS_CFG) begin
			err_class <= CLASS_NONE; // Good config clears the recoverable error
			err_ext <= '0;
		end
	end

	// Accepted configuration; a bad word leaves the old one in force
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			config_q <= 16'h0000;
		end else if (cfg_wr && !cfg_bad) begin
			config_q <= pwdata[15:0];
		end
	end

	// Control bits; a fault drops the run request so software must re-arm
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl <= 5'h00;
		end else if (apb_wr && paddr == OFS_CTRL) begin
			ctrl <= pwdata[4:0];
		end else if (module_fault) begin
			ctrl[CTRL_RUN] <= 1'b0;
		end
	end

	// Output values, zeroed on any fault
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			for (int i = 0; i < CHANNELS; i++) out_val[i] <= '0;
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (module_fault) out_val[i] <= '0;
				else if (apb_wr && paddr == OFS_OUT_BASE + 8'(4 * i)) out_val[i] <= pwdata[DATA_W-1:0];
			end
		end
	end

	// Drive outputs from flops; fault blocks the stored value too
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			analog_out <= '0;
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				analog_out[i*DATA_W +: DATA_W] <= module_fault ? '0 : out_val[i];
			end
		end
	end

	// ****************************************
	// Interrupts: sticky, write one to clear, set wins
	// ****************************************
	logic [IRQ_W-1:0] ev;
	// Events that set status bits this cycle
	always_comb begin
		ev = '0;
		ev[IRQ_CFG_ERR] = cfg_bad && state == ST_NORMAL;
		ev[IRQ_HW_ERR] = state != ST_FAULT && (hw_s2 || (state == ST_SELFTEST && stf_s2));
		ev[IRQ_RANGE] = range_any;
		ev[IRQ_RUN_LOST] = module_fault && ctrl[CTRL_RUN];
	end

	// Sticky status: an event in the clear cycle keeps its bit set
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq_stat <= '0;
		end else if (apb_wr && paddr == OFS_IRQ_STAT) begin
			irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | ev;
		end else begin
			irq_stat <= irq_stat | ev;
		end
	end

	// Mask, same layout as status
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq_mask <= '0;
		end else if (apb_wr && paddr == OFS_IRQ_MASK) begin
			irq_mask <= pwdata[IRQ_W-1:0];
		end
	end

	assign irq = |(irq_stat & irq_mask);

	// ****************************************
	// Lamps and run mode
	// ****************************************
	// One flop per lamp, so each lamp has a single owning process
	logic lamp_supply, lamp_execute, lamp_error, lamp_override, lamp_ok;

	// Supply lamp lit whenever the block is out of reset
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			lamp_supply <= 1'b0;
		end else begin
			lamp_supply <= 1'b1;
		end
	end

	// Run and execute follow the run request, blocked by a module fault; execute also by a controller fault
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			run_mode <= 1'b0;
			lamp_execute <= 1'b0;
		end else begin
			run_mode <= ctrl[CTRL_RUN] && !module_fault;
			lamp_execute <= ctrl[CTRL_RUN] && !module_fault && !ctrl[CTRL_CPU_HW];
		end
	end

	// Error lamp: steady for a controller fault, flashing for an application fault
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			lamp_error <= 1'b0;
		end else if (ctrl[CTRL_CPU_HW]) begin
			lamp_error <= 1'b1;
		end else if (ctrl[CTRL_APP_FAULT]) begin
			lamp_error <= phase;
		end else begin
			lamp_error <= 1'b0;
		end
	end

	// Override lamp; shares the flash phase so all flashing lamps stay in step
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			lamp_override <= 1'b0;
		end else if (!ctrl[CTRL_FORCES]) begin
			lamp_override <= 1'b0;
		end else if (ctrl[CTRL_FORCE_EN]) begin
			lamp_override <= 1'b1;
		end else begin
			lamp_override <= phase;
		end
	end

	// Status lamp lit only in proper operation
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			lamp_ok <= 1'b0;
		end else begin
			lamp_ok <= state == ST_NORMAL;
		end
	end

	// Lamp flops gathered onto the panel port
	assign lamps = '{
		supply: lamp_supply,
		execute: lamp_execute,
		error: lamp_error,
		override: lamp_override,
		module_ok: lamp_ok
	};

	// ****************************************
	// APB read path: zero wait states
	// ****************************************
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			prdata <= 32'h0;
		end else if (apb_rd_setup) begin
			prdata <= 32'h0; // Unmapped reads as zero
			if (paddr == OFS_ERROR_WORD) prdata <= {16'h0, pack_err(err_class, err_ext)};
			else if (paddr == OFS_CTRL) prdata <= {27'h0, ctrl};
			else if (paddr == OFS_CONFIG) prdata <= {16'h0, config_q};
			else if (paddr == OFS_STATUS) prdata <= {24'h0, 4'(state), hw_s2, range_any, run_mode, lamps.module_ok};
			else if (paddr == OFS_IRQ_STAT) prdata <= {28'h0, irq_stat};
			else if (paddr == OFS_IRQ_MASK) prdata <= {28'h0, irq_mask};
			else begin
				for (int i = 0; i < CHANNELS; i++) begin
					if (paddr == OFS_IN_BASE + 8'(4 * i)) prdata <= {30'h0, under_s2[i], over_s2[i]};
					if (paddr == OFS_OUT_BASE + 8'(4 * i)) prdata <= 32'(out_val[i]);
				end
			end
		end
	end

endmodule : dsr_top

/* tb/dsr_top_asserts.sv */
// Checker for lamp, fault and run timing at the reporter's ports
module dsr_top_asserts #(
	parameter int CHANNELS = 4,
	parameter int DATA_W = 16,
	parameter int SELFTEST_CYCLES = dsr_pkg::SELFTEST_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Watched ports
	input wire logic penable,
	input wire logic pwrite,
	input wire logic hw_fault_in,
	input wire logic selftest_fail,
	input wire logic [CHANNELS*DATA_W-1:0] analog_out,
	input wire dsr_pkg::dsr_lamps_t lamps,
	input wire logic run_mode
);
	timeunit 1ns;
	timeprecision 1ns;
	import dsr_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Edges since release; saturates so it never wraps
	int up_cnt;
	always_ff @(posedge clk) begin
		if (!rst_b)
			up_cnt <= 0;
		else if (up_cnt < 1000)
			up_cnt <= up_cnt + 1;
	end
	// Flash half period is four cycles in the bench build
	sequence s_err_dark;
		!lamps.error [*4];
	endsequence
	sequence s_ovr_lit;
		lamps.override [*4];
	endsequence
	sequence s_out_zero;
		(analog_out == '0) [*4];
	endsequence
	a_supply_lit: assert property ($past(rst_b) |-> lamps.supply)
		else $error("supply dark");
	a_exec_needs_run: assert property (lamps.execute |-> run_mode)
		else $error("execute without run");
	a_err_flash_half: assert property ($fell(lamps.error) |-> s_err_dark)
		else $error("error dark phase short");
	a_ovr_lit_half: assert property ($rose(lamps.override) |-> s_ovr_lit)
		else $error("override lit phase short");
	a_selftest_len: assert property ($rose(lamps.module_ok) |-> up_cnt >= SELFTEST_CYCLES
		&& up_cnt <= SELFTEST_CYCLES + 3) else $error("self test length wrong");
	a_fault_out_zero: assert property ($fell(lamps.module_ok) |-> ##[0:1] s_out_zero)
		else $error("outputs live in fault");
	a_fault_stops_run: assert property ($fell(lamps.module_ok) |-> ##[0:1] !run_mode [*4])
		else $error("run kept in fault");
	a_run_drop_cause: assert property ($fell(run_mode) |-> $past(hw_fault_in, 3) || $past(selftest_fail, 3)
		|| $past(pwrite && penable, 1) || $past(pwrite && penable, 2)) else $error("run lost without cause");
endmodule : dsr_top_asserts

/* tb/dsr_cpu.sv */
// Controller model: APB master that reads status and writes commands
module dsr_cpu (
	// Clock
	input wire logic clk,
	// APB master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	// Slave never answered
	output logic hung
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle bus at time zero
	initial begin
		{psel, penable, pwrite, paddr, pwdata, hung} = '0;
	end
	// One transfer; latency is bounded, never assumed
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		hung = (pready !== 1'h1);
		rd = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
		// Released data inverted so stale data never looks live
		pwdata <= ~wd;
	endtask : xfer
endmodule : dsr_cpu

/* tb/dsr_top_bench.sv */
// Bench for the diagnostic status reporter
module dsr_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import dsr_pkg::*;
	localparam int CH = 4;
	localparam int DW = 16;
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic psel, penable, pwrite, pready, pslverr, hung, run_mode, irq, hw_fault_in, selftest_fail;
	logic [7:0] paddr, gc;
	logic [31:0] pwdata, prdata, q, d;
	logic [CH-1:0] ch_over, ch_under, o, u;
	logic [CH*DW-1:0] analog_out;
	dsr_lamps_t lamps;
	int fails = 0;
	int checks_done = 0;
	int i, c, n;
	// 20 MHz clock
	always #25 clk = ~clk;
	// Short self test and flash keep the run brief
	dsr_top #(.CHANNELS(CH), .DATA_W(DW), .SELFTEST_CYCLES(8), .FLASH_HALF(4)) DUT (.clk(clk), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ch_over(ch_over), .ch_under(ch_under), .hw_fault_in(hw_fault_in),
		.selftest_fail(selftest_fail), .analog_out(analog_out), .lamps(lamps), .run_mode(run_mode), .irq(irq));
	dsr_cpu cpu (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .hung(hung));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	// Register write; a hung bus counts as a mismatch and ends the run
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		cpu.xfer(a, 1'h1, wd, q);
		if (hung) begin
			fails++;
			close_out();
		end
		chk("slverr", pslverr, 0);
		// Flops loaded by the write settle before anyone looks
		@(negedge clk);
	endtask : wr
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] e);
		cpu.xfer(a, 1'h0, 32'h0, q);
		if (hung) begin
			fails++;
			close_out();
		end
		chk(what, q, e);
	endtask : rchk
	// Let synchronisers and state catch up
	task automatic settle();
		repeat (6) @(negedge clk);
	endtask : settle
	// Bounded wait for a lamp level
	task automatic await(input int b, input logic val);
		int k;
		for (k = 0; k < 40 && lamps[b] !== val; k++)
			@(negedge clk);
		if (k == 40) begin
			fails++;
			close_out();
		end
	endtask : await
	// Lit samples over three flash periods
	task automatic lit(input int b, output int cnt);
		settle();
		cnt = 0;
		repeat (24) begin
			@(negedge clk);
			cnt += int'(lamps[b] === 1'h1);
		end
	endtask : lit
	function automatic logic [31:0] cfg_err(input int k);
		return {20'h0, CLASS_CFG, 9'(k + 1)};
	endfunction : cfg_err
	initial begin
		{ch_over, ch_under, hw_fault_in, selftest_fail} = '0;
		d = $urandom(32'hBEB3114E);
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		rchk("pwrup", OFS_ERROR_WORD, 32'h201);
		await(0, 1'h1);
		chk("supply", lamps.supply, 1);
		rchk("none", OFS_ERROR_WORD, 0);
		wr(OFS_CTRL, 32'h1);
		settle();
		chk("exec", lamps.execute, 1);
		wr(OFS_CTRL, 32'h7);
		lit(1, n);
		chk("ovr on", n, 24);
		wr(OFS_CTRL, 32'h5);
		lit(1, n);
		chk("ovr flash", n, 12);
		// Clear only at a dark phase start
		await(1, 1'h1);
		await(1, 1'h0);
		wr(OFS_CTRL, 32'h1);
		lit(1, n);
		chk("ovr off", n, 0);
		wr(OFS_CTRL, 32'h11);
		lit(2, n);
		chk("err flash", n, 12);
		wr(OFS_CTRL, 32'h1);
		settle();
		wr(OFS_CTRL, 32'h9);
		lit(2, n);
		chk("err on", n, 24);
		chk("exec off", lamps.execute, 0);
		wr(OFS_CTRL, 32'h1);
		// Range flags, all-ones corners first
		for (i = 0; i < 5; i++) begin
			o = (i == 0) ? '1 : CH'($urandom);
			u = (i == 1) ? '1 : CH'($urandom);
			@(posedge clk);
			ch_over <= o;
			ch_under <= u;
			settle();
			for (c = 0; c < CH; c++)
				rchk("in", OFS_IN_BASE + 8'(4 * c), {30'h0, u[c], o[c]});
			chk("run", run_mode, 1);
		end
		wr(OFS_IRQ_MASK, 32'h1 << IRQ_RANGE);
		chk("irq", irq, 1);
		wr(OFS_IRQ_MASK, 32'h0);
		chk("irq mask", irq, 0);
		wr(OFS_IRQ_MASK, 32'h1 << IRQ_RANGE);
		@(posedge clk);
		{ch_over, ch_under} <= '0;
		settle();
		wr(OFS_IRQ_STAT, 32'hF);
		chk("irq clr", irq, 0);
		// Each channel in turn gets the unsupported range
		for (c = 0; c < CH; c++)
			gc[2*c+:2] = 2'($urandom % 3);
		wr(OFS_CONFIG, {24'h0, gc});
		for (c = 0; c < CH; c++) begin
			wr(OFS_CONFIG, {24'h0, gc | (8'h3 << 2 * c)});
			rchk("cfg err", OFS_ERROR_WORD, cfg_err(c));
			rchk("cfg kept", OFS_CONFIG, {24'h0, gc});
			chk("run", run_mode, 1);
		end
		wr(OFS_CONFIG, {24'h0, gc});
		rchk("cfg ok", OFS_ERROR_WORD, 0);
		for (c = 0; c < CH; c++) begin
			d = $urandom;
			wr(OFS_OUT_BASE + 8'(4 * c), {16'h0, d[15:0]});
			settle();
			chk("out", analog_out[c*DW+:DW], d[15:0]);
		end
		rchk("unmapped", 8'h3C, 0);
		@(posedge clk);
		hw_fault_in <= 1'h1;
		settle();
		chk("out zero", {31'h0, |analog_out}, 0);
		chk("run off", run_mode, 0);
		rchk("hw", OFS_ERROR_WORD, 32'h200);
		// Second reset with a failing self test
		@(posedge clk);
		rst_b <= 1'h0;
		hw_fault_in <= 1'h0;
		selftest_fail <= 1'h1;
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		repeat (20) @(negedge clk);
		chk("ok dark", lamps.module_ok, 0);
		close_out();
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		close_out();
	end
endmodule : dsr_top_bench
bind dsr_top dsr_top_asserts #(.CHANNELS(CHANNELS), .DATA_W(DATA_W), .SELFTEST_CYCLES(SELFTEST_CYCLES)) u_chk (
	.clk(clk), .rst_b(rst_b), .penable(penable), .pwrite(pwrite), .hw_fault_in(hw_fault_in),
	.selftest_fail(selftest_fail), .analog_out(analog_out), .lamps(lamps), .run_mode(run_mode));
